/* File: core/psdc_consts.vh */
// constants for the synthesizer dividers and clock output block
`ifndef PSDC_CONSTS_VH
`define PSDC_CONSTS_VH
`define PSDC_MAIN_W 13
`define PSDC_SWAL_W 7
`define PSDC_LO2_W 14
`define PSDC_REF_W 12
`define PSDC_CAP_W 3
`define PSDC_CLKSEL_W 3
`define PSDC_RST_MAIN 13'h0001
`define PSDC_RST_SWAL 7'h00
`define PSDC_RST_LO2 14'h0001
`define PSDC_RST_REF 12'h0001
`define PSDC_RST_CLKSEL 3'h0
`define PSDC_HALF_W 9
`define PSDC_RST_CAP 8'h01
`define PSDC_RST_HALF 9'h001
`define PSDC_HALVES_DIV2 {9'h001, 9'h001}
`define PSDC_HALVES_DIV3 {9'h002, 9'h001}
`define PSDC_HALVES_DIV4 {9'h002, 9'h002}
`define PSDC_HALVES_DIV5 {9'h003, 9'h002}
`define PSDC_HALVES_DIV2P5 {9'h001, 9'h001}
`define PSDC_HALVES_DIV20 {9'h00a, 9'h00a}
`define PSDC_HALVES_DIV80 {9'h028, 9'h028}
`define PSDC_HALVES_DIV312P5 {9'h09c, 9'h09c}
`endif

/* File: core/psdc_section.v */
// one transmit or receive synthesizer section: dual-modulus divider and pfd
`timescale 1ns/1ps
`include "psdc_consts.vh"
module psdc_section (
  input wire clk, // system clock
  input wire rst_n, // async reset, active low
  input wire presc_pulse, // one-cycle pulse per prescaler output edge
  input wire ref_pulse, // one-cycle pulse per reference period
  input wire [12:0] main_div, // main divider value
  input wire [6:0] swallow, // swallow count
  input wire gain_hi, // charge pump high current
  input wire pol_inv, // phase detector inverted
  output reg mod_ctrl, // 1 requests larger modulus
  output reg fb_pulse, // divided feedback pulse
  output reg pump_up, // pump sources current
  output reg pump_dn, // pump sinks current
  output reg pump_hi // pump gain actually applied
);
  reg [12:0] main_cnt;
  reg [6:0] swal_cnt;
  reg up_raw;
  reg dn_raw;
  wire fb_end;
  assign fb_end = presc_pulse && (main_cnt <= 13'h0001);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_cnt <= `PSDC_RST_MAIN;
      swal_cnt <= `PSDC_RST_SWAL;
      mod_ctrl <= 1'b0;
      fb_pulse <= 1'b0;
    end else begin
      fb_pulse <= fb_end;
      if (presc_pulse) begin
        if (fb_end) begin
          main_cnt <= main_div;
          swal_cnt <= swallow;
          mod_ctrl <= (swallow != 7'h00);
        end else begin
          main_cnt <= main_cnt - 13'h0001;
          if (swal_cnt > 7'h01) begin
            swal_cnt <= swal_cnt - 7'h01;
          end else begin
            swal_cnt <= 7'h00;
            mod_ctrl <= 1'b0;
          end
        end
      end
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_raw <= 1'b0;
      dn_raw <= 1'b0;
    end else begin
      if ((up_raw || ref_pulse) && (dn_raw || fb_pulse)) begin
        up_raw <= 1'b0;
        dn_raw <= 1'b0;
      end else begin
        up_raw <= up_raw || ref_pulse;
        dn_raw <= dn_raw || fb_pulse;
      end
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
      pump_hi <= 1'b0;
    end else begin
      pump_up <= pol_inv ? dn_raw : up_raw;
      pump_dn <= pol_inv ? up_raw : dn_raw;
      pump_hi <= gain_hi;
    end
  end
endmodule

/* File: core/psdc_top.v */
// synthesizer reference, three loops, modulus drive and host clock divider
`timescale 1ns/1ps
`include "psdc_consts.vh"
module psdc_top (
  input wire clk, // reference oscillator clock
  input wire rst_n, // async reset, active low
  input wire [11:0] ref_div, // reference counter value
  input wire tx_presc, // tx prescaler edge pulse
  input wire [12:0] tx_main, // tx main divider
  input wire [6:0] tx_swal, // tx swallow count
  input wire tx_gain, // tx pump high gain
  input wire tx_pol, // tx inverted polarity
  input wire rx_presc, // rx prescaler edge pulse
  input wire [12:0] rx_main, // rx main divider
  input wire [6:0] rx_swal, // rx swallow count
  input wire rx_gain, // rx pump high gain
  input wire rx_pol, // rx inverted polarity
  input wire mod_volt, // 1 voltage, 0 current modulus drive
  input wire lo2_vco, // second oscillator vco edge pulse
  input wire [13:0] lo2_div, // second oscillator divider
  input wire lo2_gain, // second oscillator high gain
  input wire lo2_pol, // second oscillator inverted polarity
  input wire [2:0] cap_sel, // tuning capacitor select
  input wire [2:0] clk_sel, // host clock divide select
  output reg ref_tick, // synthesizer reference pulse
  output wire tx_mod, // tx modulus control
  output wire rx_mod, // rx modulus control
  output reg mod_volt_mode, // modulus drive is voltage
  output wire tx_up, // tx pump source
  output wire tx_dn, // tx pump sink
  output wire tx_hi, // tx pump gain
  output wire rx_up, // rx pump source
  output wire rx_dn, // rx pump sink
  output wire rx_hi, // rx pump gain
  output reg lo2_up, // lo2 pump source
  output reg lo2_dn, // lo2 pump sink
  output reg lo2_hi, // lo2 pump gain
  output reg [7:0] cap_en, // tuning capacitor switch, one-hot
  output reg [2:0] clk_sel_q, // held divide select
  output reg mcu_clk // host clock output
);
  // ==========================================================
  // reference counter
  reg [11:0] ref_cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= `PSDC_RST_REF;
      ref_tick <= 1'b0;
    end else if (ref_cnt <= 12'h001) begin
      ref_cnt <= ref_div;
      ref_tick <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt - 12'h001;
      ref_tick <= 1'b0;
    end
  end
  // ==========================================================
  // transmit and receive sections
  wire [1:0] presc_v;
  wire [25:0] main_v;
  wire [13:0] swal_v;
  wire [1:0] gain_v;
  wire [1:0] pol_v;
  wire [1:0] mod_v;
  wire [1:0] up_v;
  wire [1:0] dn_v;
  wire [1:0] hi_v;
  assign presc_v = {rx_presc, tx_presc};
  assign main_v = {rx_main, tx_main};
  assign swal_v = {rx_swal, tx_swal};
  assign gain_v = {rx_gain, tx_gain};
  assign pol_v = {rx_pol, tx_pol};
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_sec
      psdc_section u_sec (
        .clk(clk),
        .rst_n(rst_n),
        .presc_pulse(presc_v[i]),
        .ref_pulse(ref_tick),
        .main_div(main_v[i*13 +: 13]),
        .swallow(swal_v[i*7 +: 7]),
        .gain_hi(gain_v[i]),
        .pol_inv(pol_v[i]),
        .mod_ctrl(mod_v[i]),
        .fb_pulse(),
        .pump_up(up_v[i]),
        .pump_dn(dn_v[i]),
        .pump_hi(hi_v[i])
      );
    end
  endgenerate
  assign tx_mod = mod_v[0];
  assign rx_mod = mod_v[1];
  assign tx_up = up_v[0];
  assign rx_up = up_v[1];
  assign tx_dn = dn_v[0];
  assign rx_dn = dn_v[1];
  assign tx_hi = hi_v[0];
  assign rx_hi = hi_v[1];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_volt_mode <= 1'b0;
    end else begin
      mod_volt_mode <= mod_volt;
    end
  end
  // ==========================================================
  // second oscillator loop
  reg [13:0] lo2_cnt;
  reg lo2_fb;
  reg l_up;
  reg l_dn;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo2_cnt <= `PSDC_RST_LO2;
      lo2_fb <= 1'b0;
    end else begin
      lo2_fb <= lo2_vco && (lo2_cnt <= 14'h0001);
      if (lo2_vco) begin
        if (lo2_cnt <= 14'h0001) begin
          lo2_cnt <= lo2_div;
        end else begin
          lo2_cnt <= lo2_cnt - 14'h0001;
        end
      end
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      l_up <= 1'b0;
      l_dn <= 1'b0;
    end else if ((l_up || ref_tick) && (l_dn || lo2_fb)) begin
      l_up <= 1'b0;
      l_dn <= 1'b0;
    end else begin
      l_up <= l_up || ref_tick;
      l_dn <= l_dn || lo2_fb;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo2_up <= 1'b0;
      lo2_dn <= 1'b0;
      lo2_hi <= 1'b0;
    end else begin
      lo2_up <= lo2_pol ? l_dn : l_up;
      lo2_dn <= lo2_pol ? l_up : l_dn;
      lo2_hi <= lo2_gain;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_en <= `PSDC_RST_CAP;
    end else begin
      cap_en <= 8'h01 << cap_sel;
    end
  end
  // ==========================================================
  // host clock output divider
  // half periods in reference cycles: low half, high half
  function [17:0] psdc_halves;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: psdc_halves = `PSDC_HALVES_DIV2;
        3'h1: psdc_halves = `PSDC_HALVES_DIV3;
        3'h2: psdc_halves = `PSDC_HALVES_DIV4;
        3'h3: psdc_halves = `PSDC_HALVES_DIV5;
        3'h4: psdc_halves = `PSDC_HALVES_DIV2P5;
        3'h5: psdc_halves = `PSDC_HALVES_DIV20;
        3'h6: psdc_halves = `PSDC_HALVES_DIV80;
        3'h7: psdc_halves = `PSDC_HALVES_DIV312P5;
        default: psdc_halves = `PSDC_HALVES_DIV2;
      endcase
    end
  endfunction
  reg [8:0] half_cnt;
  reg frac_ph;
  wire [17:0] halves;
  wire is_frac;
  wire [8:0] next_half;
  assign halves = psdc_halves(clk_sel_q);
  assign is_frac = (clk_sel_q == 3'h4) || (clk_sel_q == 3'h7);
  // fractional ratio adds one cycle every other period
  assign next_half = (mcu_clk ? halves[17:9] : halves[8:0])
    + {8'h00, is_frac & frac_ph & mcu_clk};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_q <= `PSDC_RST_CLKSEL;
      half_cnt <= `PSDC_RST_HALF;
      mcu_clk <= 1'b0;
      frac_ph <= 1'b0;
    end else if (half_cnt <= 9'h001) begin
      clk_sel_q <= clk_sel;
      mcu_clk <= ~mcu_clk;
      half_cnt <= next_half;
      if (mcu_clk) begin
        frac_ph <= ~frac_ph;
      end
    end else begin
      half_cnt <= half_cnt - 9'h001;
    end
  end
endmodule

/* File: testbench/psdc_asserts.sv */
// assertion checker for the synthesizer dividers and clock output
`timescale 1ns/1ps
module psdc_asserts (
  input logic clk, // clock
  input logic rst_n, // reset, active low
  input logic [11:0] ref_div, // reference count
  input logic ref_tick, // reference pulse
  input logic mod_volt, // drive select
  input logic mod_volt_mode, // drive in use
  input logic tx_gain, // tx gain
  input logic tx_hi, // tx gain out
  input logic rx_gain, // rx gain
  input logic rx_hi, // rx gain out
  input logic lo2_gain, // lo2 gain
  input logic lo2_hi, // lo2 gain out
  input logic [2:0] cap_sel, // cap select
  input logic [7:0] cap_en, // cap switches
  input logic [2:0] clk_sel, // divide select
  input logic [2:0] clk_sel_q // select in use
);
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_volt; $stable(mod_volt)[*2] |-> mod_volt_mode == mod_volt;
  endproperty
  a_volt: assert property (p_volt) else $error("drive mode wrong");
  property p_txhi; $rose(tx_gain) |=> tx_hi; endproperty
  a_txhi: assert property (p_txhi) else $error("tx gain wrong");
  property p_rxhi; $fell(rx_gain) |=> !rx_hi; endproperty
  a_rxhi: assert property (p_rxhi) else $error("rx gain wrong");
  property p_lo2hi; lo2_hi == $past(lo2_gain); endproperty
  a_lo2hi: assert property (p_lo2hi) else $error("lo2 gain wrong");
  property p_cap; cap_en == (8'h01 << $past(cap_sel)); endproperty
  a_cap: assert property (p_cap) else $error("cap switch wrong");
  property p_oh; $onehot(cap_en); endproperty
  a_oh: assert property (p_oh) else $error("cap not one-hot");
  property p_sel; $changed(clk_sel_q) |-> clk_sel_q == $past(clk_sel);
  endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_tick;
    ref_tick && ref_div > 12'h001 && $stable(ref_div) |=> !ref_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too soon");
  c_cap: cover property (cap_en == 8'h80);
  c_sel: cover property (clk_sel_q == 3'h7);
  c_volt: cover property (mod_volt_mode);
endmodule
bind psdc_top psdc_asserts u_psdc_asserts (.clk, .rst_n, .ref_div,
  .ref_tick, .mod_volt, .mod_volt_mode, .tx_gain, .tx_hi, .rx_gain,
  .rx_hi, .lo2_gain, .lo2_hi, .cap_sel, .cap_en, .clk_sel, .clk_sel_q);

/* File: testbench/psdc_prescaler.sv */
// dual-modulus prescaler model: output edge every 2 or 3 clocks
`timescale 1ns/1ps
module psdc_prescaler (
  input logic clk, // clock
  input logic run, // vco running
  input logic modc, // 1 selects larger modulus
  output logic pulse // one pulse per output edge
);
  logic [1:0] cnt = 2'h0;
  initial pulse = 1'b0;
  always @(posedge clk) begin
    pulse <= 1'b0;
    cnt <= cnt + 2'h1;
    if (!run) begin
      cnt <= 2'h0;
    end else if (cnt >= (modc ? 2'h2 : 2'h1)) begin
      pulse <= 1'b1;
      cnt <= 2'h0;
    end
  end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the synthesizer dividers and clock output
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, lo2_vco = 1'b1;
  logic [11:0] ref_div = 12'h005;
  logic [12:0] tx_main = 13'h0002, rx_main = 13'h0002;
  logic [6:0] tx_swal = 7'h00, rx_swal = 7'h00;
  logic tx_gain = 1'b0, tx_pol = 1'b0, rx_gain = 1'b0, rx_pol = 1'b0;
  logic mod_volt = 1'b0, lo2_gain = 1'b0, lo2_pol = 1'b0;
  logic [13:0] lo2_div = 14'h0002;
  logic [2:0] cap_sel = 3'h0, clk_sel = 3'h0, clk_sel_q;
  logic [7:0] cap_en;
  logic tx_presc, rx_presc, ref_tick, tx_mod, rx_mod, mod_volt_mode, pm;
  logic tx_up, tx_dn, tx_hi, rx_up, rx_dn, rx_hi, lo2_up, lo2_dn, lo2_hi;
  logic mcu_clk;
  logic [1:0] mp = 2'b00;
  int fail_count = 0, checks = 0, n[2], h[2], ln[2], lh[2];
  int dbl[8] = '{4, 6, 8, 10, 5, 40, 160, 625};
  always #10 clk = ~clk;
  psdc_top u_psdc_top (.clk, .rst_n, .ref_div, .tx_presc, .tx_main,
    .tx_swal, .tx_gain, .tx_pol, .rx_presc, .rx_main, .rx_swal, .rx_gain,
    .rx_pol, .mod_volt, .lo2_vco, .lo2_div, .lo2_gain, .lo2_pol, .cap_sel,
    .clk_sel, .ref_tick, .tx_mod, .rx_mod, .mod_volt_mode, .tx_up, .tx_dn,
    .tx_hi, .rx_up, .rx_dn, .rx_hi, .lo2_up, .lo2_dn, .lo2_hi, .cap_en,
    .clk_sel_q, .mcu_clk);
  psdc_prescaler u_psdc_prescaler_tx (.clk, .run, .modc(tx_mod),
    .pulse(tx_presc));
  psdc_prescaler u_psdc_prescaler_rx (.clk, .run, .modc(rx_mod),
    .pulse(rx_presc));
  // ==========================================
  // pulse counting per modulus cycle
  always @(posedge clk) begin
    pm <= mcu_clk;
    if (tx_presc) begin n[0]++; if (tx_mod) h[0]++; end
    if (rx_presc) begin n[1]++; if (rx_mod) h[1]++; end
  end
  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) if ({rx_mod, tx_mod} >> i & !mp[i]) begin
      ln[i] = n[i]; lh[i] = h[i]; n[i] = 0; h[i] = 0;
    end
    mp <= {rx_mod, tx_mod};
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int k); repeat (k) @(negedge clk); endtask
  task rise(output int c);
    c = 0;
    do begin @(negedge clk); c++; end while (!(mcu_clk && !pm));
  endtask
  task t_ref; int c; begin
    c = 0;
    while (!ref_tick && c < 20) begin @(negedge clk); c++; end
    c = 0;
    do begin @(negedge clk); c++; end while (!ref_tick && c < 20);
    chk(c, 5);
  end endtask
  task t_mcu; int c1, c2; begin
    for (int s = 0; s < 8; s++) begin
      clk_sel = s[2:0];
      rise(c1); rise(c1); rise(c1); rise(c2);
      chk(c1 + c2, dbl[s]);
      chk(clk_sel_q, s[2:0]);
    end
  end endtask
  task t_mod; int tot; begin
    tot = 64 * 20 + 5;
    tx_main = 13'(tot / 64); tx_swal = 7'(tot % 64);
    tot = 64 * 9 + 3;
    rx_main = 13'(tot / 64); rx_swal = 7'(tot % 64);
    mod_volt = 1'b1;
    cyc(400);
    chk(ln[0], 20);
    chk(lh[0], 5);
    chk(ln[1], 9);
    chk(lh[1], 3);
    chk(mod_volt_mode, 1);
  end endtask
  task t_pump(input logic p); int u[3], d[3]; begin
    {tx_pol, rx_pol, lo2_pol, tx_gain, rx_gain, lo2_gain} = {6{p}};
    {tx_main, rx_main, tx_swal, rx_swal} = {13'h2, 13'h2, 7'h0, 7'h0};
    ref_div = 12'h0c8;
    u = '{0, 0, 0}; d = '{0, 0, 0};
    cyc(100);
    repeat (800) begin
      @(negedge clk);
      u[0] += tx_up; d[0] += tx_dn; u[1] += rx_up; d[1] += rx_dn;
      u[2] += lo2_up; d[2] += lo2_dn;
    end
    // fast feedback must sink unless inverted
    for (int i = 0; i < 3; i++) chk(u[i] > d[i], p);
    chk({tx_hi, rx_hi, lo2_hi}, {3{p}});
  end endtask
  task t_cap;
    for (int i = 0; i < 8; i++) begin
      cap_sel = i[2:0];
      cyc(2);
      chk(cap_en, 8'h01 << i);
    end
  endtask
  task t_rst;
    cyc(4);
    chk(cap_en, 8'h01);
    chk({tx_up, tx_dn, rx_up, rx_dn, lo2_up, lo2_dn}, 0);
    chk({ref_tick, mcu_clk, clk_sel_q}, 0);
    rst_n = 1'b1;
    run = 1'b1;
  endtask
  initial begin
    t_rst;
    t_ref; t_mcu; t_mod; t_pump(1'b0); t_pump(1'b1); t_cap;
    give_verdict;
  end
  initial begin
    #(20 * 20000);
    fail_count++;
    give_verdict;
  end
endmodule
